// >>> hdl/flash_cmd_pkg.sv
package flash_cmd_pkg;

	// ************************************************************
	// opcodes
	// ************************************************************
	localparam logic [7:0] OP_READ = 8'h03; // read, three address bytes
	localparam logic [7:0] OP_FAST_READ = 8'h0b; // read, address plus dummy byte
	localparam logic [7:0] OP_SMALL_ERASE = 8'hd7; // small sector erase
	localparam logic [7:0] OP_SMALL_ERASE_ALT = 8'h20; // small sector erase, second code
	localparam logic [7:0] OP_SECTOR_ERASE = 8'hd8; // sector erase
	localparam logic [7:0] OP_CHIP_ERASE = 8'hc7; // chip erase
	localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02; // page program
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06; // write enable
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04; // write disable
	localparam logic [7:0] OP_POWER_DOWN = 8'hb9; // enter power down
	localparam logic [7:0] OP_STATUS_READ = 8'h05; // status read
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01; // status write
	localparam logic [7:0] OP_ID_READ = 8'h9f; // identification read
	localparam logic [7:0] OP_ID_LEGACY = 8'hab; // id read or power down exit

	// ************************************************************
	// widths and byte counts
	// ************************************************************
	localparam int ADDR_W = 18; // address bits that select a location
	localparam int COUNT_W = 10; // frame byte counter width
	localparam logic [COUNT_W-1:0] CNT_ONE = 10'h001; // counter step
	localparam logic [COUNT_W-1:0] CNT_MAX = 10'h3ff; // counter saturation
	localparam logic [COUNT_W-1:0] LEN_OPCODE = 10'h001; // opcode only
	localparam logic [COUNT_W-1:0] LEN_STATUS_WRITE = 10'h002; // opcode plus data
	localparam logic [COUNT_W-1:0] LEN_ADDR = 10'h004; // opcode plus address
	localparam logic [COUNT_W-1:0] LEN_FAST = 10'h005; // plus dummy byte
	localparam logic [COUNT_W-1:0] LEN_ID_TYPE = 10'h002; // second id byte position
	localparam int STATUS_LOCK_POS = 7; // status write lock bit position

	// ************************************************************
	// command stream
	// ************************************************************
	typedef enum logic [3:0] {
		KIND_SMALL_ERASE = 4'h1,
		KIND_SECTOR_ERASE = 4'h2,
		KIND_CHIP_ERASE = 4'h3,
		KIND_PAGE_PROGRAM = 4'h4,
		KIND_PAGE_DATA = 4'h5,
		KIND_WRITE_ENABLE = 4'h6,
		KIND_WRITE_DISABLE = 4'h7,
		KIND_POWER_DOWN = 4'h8,
		KIND_POWER_UP = 4'h9,
		KIND_STATUS_WRITE = 4'ha
	} kind_t;

	typedef struct packed {
		kind_t kind; // what to do
		logic [ADDR_W-1:0] addr; // location
		logic [7:0] data; // status byte or page data
	} cmd_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_CHECK = 4'h2,
		ST_HEAD = 4'h4,
		ST_DATA = 4'h8
	} sys_state_t;

	// ************************************************************
	// state records
	// ************************************************************
	typedef struct packed {
		logic started; // an edge was seen in this frame
		logic mode3; // clock was high at select
		logic [2:0] bit_cnt; // bit within byte
		logic [7:0] shift; // incoming byte
		logic [ADDR_W-1:0] rd_ptr; // read address
	} link_rise_t;

	typedef struct packed {
		logic frame_tog; // flips once per frame
		logic partial; // a byte is incomplete
		logic [COUNT_W-1:0] count; // whole bytes taken
		logic [7:0] opcode; // first byte
		logic [ADDR_W-1:0] addr; // address bytes
		logic [7:0] data0; // second byte
	} link_rec_t;

	typedef struct packed {
		logic saw_fall; // falling edge seen in frame
		logic so; // output bit
		logic so_en; // output driven
	} link_fall_t;

	typedef struct packed {
		sys_state_t state;
		logic cs_meta;
		logic cs_sync;
		logic cs_prev;
		logic mode_meta;
		logic mode_sync;
		logic wp_meta;
		logic wp_sync;
		logic seen_tog; // last frame handled
		logic power_down; // powered down
		logic [7:0] status; // status snapshot
		cmd_t head; // command to emit
		logic [COUNT_W-1:0] idx; // page byte index
		logic [COUNT_W-1:0] left; // page bytes left
		cmd_t [1:0] buf_ent; // two entry buffer
		logic buf_wr; // buffer write slot
		logic buf_rd; // buffer read slot
		logic [1:0] buf_cnt; // buffer fill
	} sys_t;

	localparam link_rise_t LINK_RISE_RESET = '0;
	localparam link_rec_t LINK_REC_RESET = '0;
	localparam link_fall_t LINK_FALL_RESET = '0;
	localparam logic [1:0] BUF_FULL = 2'h2;

endpackage : flash_cmd_pkg

// >>> hdl/serial_flash_command_port.sv
`timescale 1ns/1ps
module serial_flash_command_port #(
	parameter int PAGE_BYTES = 256,
	parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
	parameter logic [7:0] TYPE_ID = 8'h3c, // arbitrary value
	parameter logic [7:0] CAP_ID = 8'h12, // arbitrary value
	parameter logic [7:0] LEGACY_ID = 8'h21 // arbitrary value
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	output logic so,
	output logic so_oe_n,
	input wire logic wp_n,
	input wire logic hold_n,
	output logic [flash_cmd_pkg::ADDR_W-1:0] read_addr,
	input wire logic [7:0] read_data,
	input wire logic [7:0] status_in,
	output logic cmd_valid,
	input wire logic cmd_ready,
	output flash_cmd_pkg::cmd_t cmd,
	output logic spi_mode3,
	output logic powered_down
);

	localparam int PAGE_AW = $clog2(PAGE_BYTES); // page index width
	localparam logic [flash_cmd_pkg::COUNT_W-1:0] PAGE_CNT = PAGE_BYTES[flash_cmd_pkg::COUNT_W-1:0];

	// ************************************************************
	// link side state
	// ************************************************************
	flash_cmd_pkg::link_rise_t rise_q, rise_d; // cleared per frame
	flash_cmd_pkg::link_rec_t rec_q, rec_d; // survives select rise
	flash_cmd_pkg::link_fall_t fall_q, fall_d; // output launch
	flash_cmd_pkg::sys_t sys_q, sys_d; // system clock state
	logic [7:0] page_mem [PAGE_BYTES]; // page program bytes
	logic link_reset; // reset or deselected
	logic mem_we; // page byte write
	logic [PAGE_AW-1:0] mem_idx; // page byte slot
	logic tx_on; // output phase of a read
	logic [7:0] tx_byte; // byte being sent

	// deselect clears the frame logic at once
	assign link_reset = reset | cs_n;

	// ************************************************************
	// rising edge: command, address and data in
	// ************************************************************

	// next frame and record state
	always_comb begin
		logic [7:0] byte_in;
		logic [flash_cmd_pkg::COUNT_W-1:0] cnt;
		logic done;
		byte_in = {rise_q.shift[6:0], si};
		cnt = rise_q.started ? rec_q.count : '0;
		done = (rise_q.bit_cnt == 3'h7);
		rise_d = rise_q;
		rec_d = rec_q;
		mem_we = 1'b0;
		mem_idx = '0;
		// hold low freezes the rise and record state (saw_fall still sets on a falling edge); an edge while deselected is ignored
		if (hold_n && !cs_n) begin
			rise_d.shift = byte_in;
			rise_d.bit_cnt = rise_q.bit_cnt + 3'h1;
			rec_d.partial = ~done;
			rec_d.count = cnt;
			// first edge opens the frame
			if (!rise_q.started) begin
				rise_d.started = 1'b1;
				rise_d.mode3 = fall_q.saw_fall;
				rec_d.frame_tog = ~rec_q.frame_tog;
			end
			// byte boundary
			if (done) begin
				if (cnt != flash_cmd_pkg::CNT_MAX) begin
					rec_d.count = cnt + flash_cmd_pkg::CNT_ONE;
				end
				if (cnt == '0) begin
					rec_d.opcode = byte_in;
				end else if (cnt < flash_cmd_pkg::LEN_ADDR) begin
					// upper address bits fall off the top
					rec_d.addr = {rec_q.addr[flash_cmd_pkg::ADDR_W-9:0], byte_in};
				end
				if (cnt == flash_cmd_pkg::CNT_ONE) begin
					rec_d.data0 = byte_in;
				end
				// read pointer: load at address end, step per sent byte
				if (cnt == flash_cmd_pkg::LEN_ADDR - flash_cmd_pkg::CNT_ONE) begin
					rise_d.rd_ptr = {rec_q.addr[flash_cmd_pkg::ADDR_W-9:0], byte_in};
				end else if ((rec_q.opcode == flash_cmd_pkg::OP_READ &&
						cnt >= flash_cmd_pkg::LEN_ADDR) ||
						(rec_q.opcode == flash_cmd_pkg::OP_FAST_READ &&
						cnt >= flash_cmd_pkg::LEN_FAST)) begin
					rise_d.rd_ptr = rise_q.rd_ptr + 18'h00001;
				end
				// page data goes to the page store
				if (rec_q.opcode == flash_cmd_pkg::OP_PAGE_PROGRAM &&
						cnt >= flash_cmd_pkg::LEN_ADDR) begin
					mem_we = 1'b1;
					mem_idx = cnt[PAGE_AW-1:0] - PAGE_AW'(flash_cmd_pkg::LEN_ADDR);
				end
			end
		end
	end

	// frame registers, cleared by deselect
	always_ff @(posedge sck or posedge link_reset) begin
		if (link_reset) begin
			rise_q <= flash_cmd_pkg::LINK_RISE_RESET;
		end else begin
			rise_q <= rise_d;
		end
	end

	// record registers, read by the system side after select rise
	always_ff @(posedge sck or posedge reset) begin
		if (reset) begin
			rec_q <= flash_cmd_pkg::LINK_REC_RESET;
		end else begin
			rec_q <= rec_d;
		end
	end

	// page store write port
	always_ff @(posedge sck) begin
		if (mem_we) begin
			page_mem[mem_idx] <= rise_d.shift;
		end
	end

	assign read_addr = rise_q.rd_ptr;

	// ************************************************************
	// output selection
	// ************************************************************

	// which byte goes out, and whether the pin is driven
	always_comb begin
		tx_on = 1'b0;
		tx_byte = 8'h00;
		if (rise_q.started) begin
			case (rec_q.opcode)
				flash_cmd_pkg::OP_READ: begin
					tx_on = rec_q.count >= flash_cmd_pkg::LEN_ADDR;
					tx_byte = read_data;
				end
				flash_cmd_pkg::OP_FAST_READ: begin
					tx_on = rec_q.count >= flash_cmd_pkg::LEN_FAST;
					tx_byte = read_data;
				end
				flash_cmd_pkg::OP_STATUS_READ: begin
					tx_on = rec_q.count >= flash_cmd_pkg::LEN_OPCODE;
					tx_byte = sys_q.status;
				end
				flash_cmd_pkg::OP_ID_READ: begin
					tx_on = rec_q.count >= flash_cmd_pkg::LEN_OPCODE;
					if (rec_q.count == flash_cmd_pkg::LEN_OPCODE) begin
						tx_byte = MAKER_ID;
					end else if (rec_q.count == flash_cmd_pkg::LEN_ID_TYPE) begin
						tx_byte = TYPE_ID;
					end else begin
						tx_byte = CAP_ID;
					end
				end
				flash_cmd_pkg::OP_ID_LEGACY: begin
					tx_on = rec_q.count >= flash_cmd_pkg::LEN_ADDR;
					tx_byte = LEGACY_ID;
				end
				default: begin
					tx_on = 1'b0;
				end
			endcase
		end
	end

	// ************************************************************
	// falling edge: output launch
	// ************************************************************

	// next output bit, most significant first
	always_comb begin
		fall_d = fall_q;
		fall_d.saw_fall = 1'b1;
		if (hold_n) begin
			fall_d.so = tx_byte[~rise_q.bit_cnt];
			fall_d.so_en = tx_on;
		end
	end

	// launch registers
	always_ff @(negedge sck or posedge link_reset) begin
		if (link_reset) begin
			fall_q <= flash_cmd_pkg::LINK_FALL_RESET;
		end else begin
			fall_q <= fall_d;
		end
	end

	assign so = fall_q.so;
	// released while shifting in, on hold and when deselected
	assign so_oe_n = ~(fall_q.so_en & hold_n);

	// ************************************************************
	// system side: decode at select rise, command stream
	// ************************************************************

	// decode, buffer and crossing
	always_comb begin
		logic ok;
		logic push;
		logic pop;
		flash_cmd_pkg::kind_t kind;
		flash_cmd_pkg::cmd_t item;
		ok = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		kind = flash_cmd_pkg::KIND_CHIP_ERASE;
		item = sys_q.head;
		sys_d = sys_q;
		sys_d.cs_meta = cs_n;
		sys_d.cs_sync = sys_q.cs_meta;
		sys_d.cs_prev = sys_q.cs_sync;
		// mode of the last frame is kept until the next frame opens
		sys_d.mode_meta = rise_q.started ? rise_q.mode3 : sys_q.mode_meta;
		sys_d.mode_sync = sys_q.mode_meta;
		sys_d.wp_meta = wp_n;
		sys_d.wp_sync = sys_q.wp_meta;
		// status only changes between frames
		if (sys_q.cs_sync) begin
			sys_d.status = status_in;
		end
		case (rec_q.opcode)
			flash_cmd_pkg::OP_SMALL_ERASE, flash_cmd_pkg::OP_SMALL_ERASE_ALT: begin
				ok = rec_q.count == flash_cmd_pkg::LEN_ADDR;
				kind = flash_cmd_pkg::KIND_SMALL_ERASE;
			end
			flash_cmd_pkg::OP_SECTOR_ERASE: begin
				ok = rec_q.count == flash_cmd_pkg::LEN_ADDR;
				kind = flash_cmd_pkg::KIND_SECTOR_ERASE;
			end
			flash_cmd_pkg::OP_CHIP_ERASE: begin
				ok = rec_q.count == flash_cmd_pkg::LEN_OPCODE;
				kind = flash_cmd_pkg::KIND_CHIP_ERASE;
			end
			flash_cmd_pkg::OP_PAGE_PROGRAM: begin
				ok = rec_q.count > flash_cmd_pkg::LEN_ADDR;
				kind = flash_cmd_pkg::KIND_PAGE_PROGRAM;
			end
			flash_cmd_pkg::OP_WRITE_ENABLE: begin
				ok = rec_q.count == flash_cmd_pkg::LEN_OPCODE;
				kind = flash_cmd_pkg::KIND_WRITE_ENABLE;
			end
			flash_cmd_pkg::OP_WRITE_DISABLE: begin
				ok = rec_q.count == flash_cmd_pkg::LEN_OPCODE;
				kind = flash_cmd_pkg::KIND_WRITE_DISABLE;
			end
			flash_cmd_pkg::OP_POWER_DOWN: begin
				ok = rec_q.count == flash_cmd_pkg::LEN_OPCODE;
				kind = flash_cmd_pkg::KIND_POWER_DOWN;
			end
			flash_cmd_pkg::OP_ID_LEGACY: begin
				ok = rec_q.count == flash_cmd_pkg::LEN_OPCODE;
				kind = flash_cmd_pkg::KIND_POWER_UP;
			end
			flash_cmd_pkg::OP_STATUS_WRITE: begin
				// the lock only bites while protect is low
				ok = rec_q.count == flash_cmd_pkg::LEN_STATUS_WRITE &&
					!(sys_q.status[flash_cmd_pkg::STATUS_LOCK_POS] && !sys_q.wp_sync);
				kind = flash_cmd_pkg::KIND_STATUS_WRITE;
			end
			default: begin
				ok = 1'b0;
			end
		endcase
		// torn byte, stale frame or asleep: drop it
		ok = ok && !rec_q.partial && rec_q.frame_tog != sys_q.seen_tog &&
			(!sys_q.power_down || kind == flash_cmd_pkg::KIND_POWER_UP);
		case (sys_q.state)
			flash_cmd_pkg::ST_IDLE: begin
				// act only at the select rise
				if (sys_q.cs_sync && !sys_q.cs_prev) begin
					sys_d.state = flash_cmd_pkg::ST_CHECK;
				end
			end
			flash_cmd_pkg::ST_CHECK: begin
				sys_d.seen_tog = rec_q.frame_tog;
				sys_d.head = '{kind: kind, addr: rec_q.addr, data: rec_q.data0};
				sys_d.idx = '0;
				sys_d.left = rec_q.count - flash_cmd_pkg::LEN_ADDR;
				if (rec_q.count - flash_cmd_pkg::LEN_ADDR > PAGE_CNT) begin
					sys_d.left = PAGE_CNT;
				end
				sys_d.state = ok ? flash_cmd_pkg::ST_HEAD : flash_cmd_pkg::ST_IDLE;
			end
			flash_cmd_pkg::ST_HEAD: begin
				push = 1'b1;
				if (sys_q.buf_cnt != flash_cmd_pkg::BUF_FULL) begin
					if (sys_q.head.kind == flash_cmd_pkg::KIND_POWER_DOWN) begin
						sys_d.power_down = 1'b1;
					end else if (sys_q.head.kind == flash_cmd_pkg::KIND_POWER_UP) begin
						sys_d.power_down = 1'b0;
					end
					sys_d.state = (sys_q.head.kind == flash_cmd_pkg::KIND_PAGE_PROGRAM) ?
						flash_cmd_pkg::ST_DATA : flash_cmd_pkg::ST_IDLE;
				end
			end
			flash_cmd_pkg::ST_DATA: begin
				push = 1'b1;
				item = '{kind: flash_cmd_pkg::KIND_PAGE_DATA, addr: sys_q.head.addr,
					data: page_mem[sys_q.idx[PAGE_AW-1:0]]};
				if (sys_q.buf_cnt != flash_cmd_pkg::BUF_FULL) begin
					sys_d.idx = sys_q.idx + flash_cmd_pkg::CNT_ONE;
					sys_d.left = sys_q.left - flash_cmd_pkg::CNT_ONE;
					if (sys_q.left == flash_cmd_pkg::CNT_ONE) begin
						sys_d.state = flash_cmd_pkg::ST_IDLE;
					end
				end
			end
			default: begin
				sys_d.state = flash_cmd_pkg::ST_IDLE;
			end
		endcase
		// two entry buffer; a full buffer stalls the emitter
		push = push && sys_q.buf_cnt != flash_cmd_pkg::BUF_FULL;
		pop = cmd_ready && sys_q.buf_cnt != 2'h0;
		if (push) begin
			sys_d.buf_ent[sys_q.buf_wr] = item;
			sys_d.buf_wr = ~sys_q.buf_wr;
		end
		if (pop) begin
			sys_d.buf_rd = ~sys_q.buf_rd;
		end
		sys_d.buf_cnt = sys_q.buf_cnt + {1'b0, push} - {1'b0, pop};
	end

	// system registers
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sys_q <= '{state: flash_cmd_pkg::ST_IDLE, cs_meta: 1'b1, cs_sync: 1'b1,
				cs_prev: 1'b1, wp_meta: 1'b1, wp_sync: 1'b1, default: '0};
		end else begin
			sys_q <= sys_d;
		end
	end

	assign cmd_valid = sys_q.buf_cnt != 2'h0;
	assign cmd = sys_q.buf_ent[sys_q.buf_rd];
	assign spi_mode3 = sys_q.mode_sync;
	assign powered_down = sys_q.power_down;

endmodule : serial_flash_command_port

// >>> verif/flash_cmd_asserts.sv
`timescale 1ns/1ps
// ********
// checker on the top ports
// ********
module flash_cmd_asserts (
	input wire logic clock,
	input wire logic reset,
	input wire logic cs_n,
	input wire logic so_oe_n,
	input wire logic hold_n,
	input wire logic wp_n,
	input wire logic [7:0] status_in,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire flash_cmd_pkg::cmd_t cmd,
	input wire logic spi_mode3,
	input wire logic powered_down
);
	default clocking cb @(posedge clock); endclocking
	// quiet outputs while reset is held
	property p_reset_quiet;
		disable iff (1'b0) reset |-> !cmd_valid && so_oe_n && !powered_down && !spi_mode3;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy in reset");
	// output released while deselected
	property p_oe_cs;
		disable iff (reset) cs_n |-> so_oe_n;
	endproperty
	a_oe_cs: assert property (p_oe_cs) else $error("so driven while deselected");
	// output released during hold
	property p_oe_hold;
		disable iff (reset) !hold_n |-> so_oe_n;
	endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("so driven during hold");
	// a new command appears only after select has risen
	property p_cs_rise;
		disable iff (reset) $rose(cmd_valid) |-> cs_n || $past(cs_n, 6);
	endproperty
	a_cs_rise: assert property (p_cs_rise) else $error("command before select rise");
	// stalled item holds still
	property p_hold_item;
		disable iff (reset) cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd);
	endproperty
	a_hold_item: assert property (p_hold_item) else $error("item changed while stalled");
	// an item leaves only when taken
	property p_fall_pop;
		disable iff (reset) $fell(cmd_valid) |-> $past(cmd_ready);
	endproperty
	a_fall_pop: assert property (p_fall_pop) else $error("item dropped untaken");
	// lock honoured only with protect low
	property p_lock;
		disable iff (reset) cmd_valid && cmd.kind == flash_cmd_pkg::KIND_STATUS_WRITE
			|-> wp_n || !status_in[flash_cmd_pkg::STATUS_LOCK_POS];
	endproperty
	a_lock: assert property (p_lock) else $error("locked status write passed");
	// only known kinds leave
	property p_kind;
		disable iff (reset) cmd_valid |-> cmd.kind inside {[4'h1:4'ha]};
	endproperty
	a_kind: assert property (p_kind) else $error("unknown kind emitted");
	// powered down lets only the power down and power up items pass
	property p_pd;
		disable iff (reset) powered_down && cmd_valid
			|-> cmd.kind inside {flash_cmd_pkg::KIND_POWER_DOWN, flash_cmd_pkg::KIND_POWER_UP};
	endproperty
	a_pd: assert property (p_pd) else $error("command passed in power down");
	// main scenarios
	c_stall: cover property (disable iff (reset) cmd_valid && !cmd_ready);
	c_page: cover property (disable iff (reset) cmd_valid && cmd.kind == 4'h5);
	c_pd: cover property (disable iff (reset) $rose(powered_down));
	c_hold: cover property (disable iff (reset) !hold_n && !cs_n);
endmodule : flash_cmd_asserts

bind serial_flash_command_port flash_cmd_asserts chk_u (.clock(clock), .reset(reset),
	.cs_n(cs_n), .so_oe_n(so_oe_n), .hold_n(hold_n), .wp_n(wp_n), .status_in(status_in),
	.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .spi_mode3(spi_mode3),
	.powered_down(powered_down));

// >>> verif/spi_host_model.sv
`timescale 1ns/1ps
// ********
// spi host: select, 30 ns clock only inside frames, data
// ********
module spi_host_model (
	output logic sck,
	output logic cs_n,
	output logic si,
	output logic hold_n,
	input wire logic so
);
	// idle levels at time zero
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		hold_n = 1'b1;
	end
	// one frame of n bytes; hold_at suspends before that byte
	task automatic frame(input logic m3, input int n, input int hold_at,
		input logic [7:0] tx [16], output logic [7:0] rx [16]);
		sck = m3;
		#15 cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			// hold only with clock low, clock toggled meanwhile
			if (i == hold_at) begin
				sck = 1'b0;
				#15 hold_n = 1'b0;
				repeat (4) begin
					#15 sck = 1'b1;
					si = ~si;
					#15 sck = 1'b0;
				end
				hold_n = 1'b1;
			end
			for (int b = 7; b >= 0; b--) begin
				sck = 1'b0;
				si = tx[i][b];
				#15 sck = 1'b1;
				rx[i][b] = so;
				#15;
			end
		end
		// every frame ends with select rise
		sck = m3;
		#15 cs_n = 1'b1;
		si = ~si;
		#100;
	endtask : frame
endmodule : spi_host_model

// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam logic [7:0] ID_M = 8'h6b; // arbitrary value
	localparam logic [7:0] ID_T = 8'h4d; // arbitrary value
	localparam logic [7:0] ID_C = 8'h2e; // arbitrary value
	localparam logic [7:0] ID_L = 8'h71; // arbitrary value
	logic clock, reset, sck, cs_n, si, so, so_pin, so_oe_n, wp_n, hold_n;
	logic cmd_valid, cmd_ready, spi_mode3, powered_down;
	logic [flash_cmd_pkg::ADDR_W-1:0] read_addr;
	logic [7:0] read_data, status_in;
	flash_cmd_pkg::cmd_t cmd;
	flash_cmd_pkg::cmd_t seen [$]; // items taken
	logic [7:0] tx [16];
	logic [7:0] rx [16];
	int fails, check_count;
	// memory contents follow the address
	function automatic logic [7:0] mem(input logic [17:0] a);
		return a[7:0] ^ {6'h00, a[17:16]};
	endfunction : mem
	assign read_data = mem(read_addr);
	// released line shows the inverse
	assign so_pin = so_oe_n ? ~so : so;
	serial_flash_command_port #(.MAKER_ID(ID_M), .TYPE_ID(ID_T), .CAP_ID(ID_C),
		.LEGACY_ID(ID_L)) dut_u (.clock(clock), .reset(reset), .sck(sck), .cs_n(cs_n),
		.si(si), .so(so), .so_oe_n(so_oe_n), .wp_n(wp_n), .hold_n(hold_n),
		.read_addr(read_addr), .read_data(read_data), .status_in(status_in),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .spi_mode3(spi_mode3),
		.powered_down(powered_down));
	spi_host_model host_u (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so_pin));
	// 50 MHz clock
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// collect taken items
	always @(posedge clock) begin
		if (cmd_valid === 1'b1 && cmd_ready === 1'b1) seen.push_back(cmd);
	end
	// ********
	// compare and end
	// ********
	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : wrap_up
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %h not %h", $time, got, exp);
		end
	endtask : cmp_byte
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_byte({7'h00, got}, {7'h00, exp});
	endtask : cmp_bit
	// next item; m picks addr and data fields
	task automatic cmp_cmd(input logic [3:0] k, input logic [17:0] a, input logic [7:0] d,
		input logic [1:0] m);
		flash_cmd_pkg::cmd_t c;
		for (int t = 0; t < 200 && seen.size() == 0; t++) @(posedge clock);
		check_count++;
		if (seen.size() == 0) begin
			fails++;
			$display("unexpected at %0t: no item", $time);
			wrap_up();
		end
		c = seen.pop_front();
		if (c.kind !== k || (m[1] && c.addr !== a) || (m[0] && c.data !== d)) begin
			fails++;
			$display("unexpected at %0t: item %h", $time, c);
		end
	endtask : cmp_cmd
	task automatic no_cmd;
		repeat (30) @(posedge clock);
		cmp_bit(seen.size() == 0, 1'b1);
	endtask : no_cmd
	// ********
	// scenarios
	// ********
	task automatic t_single;
		logic [7:0] ops [4] = '{8'h06, 8'h04, 8'hc7, 8'hff};
		logic [3:0] ks [3] = '{4'h6, 4'h7, 4'h3};
		for (int i = 0; i < 4; i++) begin
			tx = '{0: ops[i], default: 8'h00};
			host_u.frame(i[0], 1, 99, tx, rx);
			if (i < 3) cmp_cmd(ks[i], 18'h0, 8'h0, 2'b00);
			else no_cmd();
			cmp_bit(spi_mode3, i[0]);
		end
	endtask : t_single
	task automatic t_erase;
		logic [7:0] ops [5] = '{8'hd7, 8'h20, 8'hd8, 8'hd8, 8'hc7};
		int ns [5] = '{4, 4, 4, 3, 2};
		logic [3:0] ks [3] = '{4'h1, 4'h1, 4'h2};
		for (int i = 0; i < 5; i++) begin
			tx = '{0: ops[i], 1: 8'hfe, 2: 8'h56, 3: 8'h78, default: 8'h00};
			host_u.frame(1'b0, ns[i], 99, tx, rx);
			if (i < 3) cmp_cmd(ks[i], 18'h25678, 8'h0, 2'b10);
			else no_cmd();
		end
	endtask : t_erase
	task automatic t_status_write;
		for (int i = 0; i < 3; i++) begin
			@(posedge clock);
			wp_n <= (i == 0);
			status_in <= (i < 2) ? 8'h80 : 8'h00;
			repeat (5) @(posedge clock);
			tx = '{0: 8'h01, 1: 8'ha5, default: 8'h00};
			host_u.frame(1'b0, 2, 99, tx, rx);
			if (i == 1) no_cmd();
			else cmp_cmd(4'ha, 18'h0, 8'ha5, 2'b01);
		end
	endtask : t_status_write
	task automatic t_page;
		@(posedge clock);
		cmd_ready <= 1'b0;
		tx = '{0: 8'h02, 1: 8'h01, 2: 8'h23, 3: 8'h45, 4: 8'h11, 5: 8'h22, 6: 8'h33,
			default: 8'h00};
		host_u.frame(1'b1, 7, 99, tx, rx);
		repeat (30) @(posedge clock);
		cmp_bit(cmd_valid, 1'b1);
		cmd_ready <= 1'b1;
		cmp_cmd(4'h4, 18'h12345, 8'h0, 2'b10);
		for (int i = 4; i < 7; i++) cmp_cmd(4'h5, 18'h12345, tx[i], 2'b11);
		no_cmd();
	endtask : t_page
	task automatic t_read;
		tx = '{0: 8'h03, 1: 8'hff, 2: 8'hff, 3: 8'hfe, default: 8'h00};
		host_u.frame(1'b0, 8, 99, tx, rx);
		for (int k = 0; k < 4; k++) cmp_byte(rx[4+k], mem(18'(18'h3fffe + k)));
		tx = '{0: 8'h0b, 1: 8'h00, 2: 8'h00, 3: 8'h10, default: 8'h00};
		host_u.frame(1'b1, 7, 99, tx, rx);
		for (int k = 0; k < 2; k++) cmp_byte(rx[5+k], mem(18'(18'h10 + k)));
		cmp_bit(so_oe_n, 1'b1);
		no_cmd();
	endtask : t_read
	task automatic t_status_id;
		@(posedge clock);
		status_in <= 8'h16;
		repeat (5) @(posedge clock);
		tx = '{0: 8'h05, default: 8'h00};
		host_u.frame(1'b0, 4, 2, tx, rx);
		for (int k = 1; k < 4; k++) cmp_byte(rx[k], 8'h16);
		tx = '{0: 8'h9f, default: 8'h00};
		host_u.frame(1'b1, 5, 99, tx, rx);
		cmp_byte(rx[1], ID_M);
		cmp_byte(rx[2], ID_T);
		cmp_byte(rx[3], ID_C);
		cmp_byte(rx[4], ID_C);
		tx = '{0: 8'hab, default: 8'h00};
		host_u.frame(1'b0, 6, 99, tx, rx);
		for (int k = 4; k < 6; k++) cmp_byte(rx[k], ID_L);
	endtask : t_status_id
	task automatic t_power;
		tx = '{0: 8'hb9, default: 8'h00};
		host_u.frame(1'b0, 1, 99, tx, rx);
		cmp_cmd(4'h8, 18'h0, 8'h0, 2'b00);
		repeat (3) @(posedge clock);
		cmp_bit(powered_down, 1'b1);
		tx = '{0: 8'h06, default: 8'h00};
		host_u.frame(1'b0, 1, 99, tx, rx);
		no_cmd();
		tx = '{0: 8'hab, default: 8'h00};
		host_u.frame(1'b1, 1, 99, tx, rx);
		cmp_cmd(4'h9, 18'h0, 8'h0, 2'b00);
		repeat (3) @(posedge clock);
		cmp_bit(powered_down, 1'b0);
	endtask : t_power
	// main sequence
	initial begin
		fails = 0;
		check_count = 0;
		reset = 1'b1;
		wp_n = 1'b1;
		status_in = 8'h00;
		cmd_ready = 1'b1;
		repeat (10) @(posedge clock);
		reset <= 1'b0;
		repeat (5) @(posedge clock);
		cmp_bit(cmd_valid, 1'b0);
		#3;
		t_single();
		t_erase();
		t_status_write();
		t_page();
		t_read();
		t_status_id();
		t_power();
		wrap_up();
	end
endmodule : testbench
